// ---- bench/ecpx_fifo_model.sv ----
// fifo storage behind the extended control block, stallable by the bench
module ecpx_fifo_model (
    input  wire logic       ref_clk,     // system clock
    input  wire logic       resetn,      // async reset, low
    input  wire logic       fifo_reset,  // hold storage empty
    input  wire logic [8:0] fifo_wdata,  // tagged write word
    input  wire logic       fifo_wvalid, // write word valid
    output logic            fifo_wready, // storage accepts
    input  wire logic       fifo_pop,    // take head byte
    output logic [4:0]      fifo_count,  // bytes held
    output logic [7:0]      fifo_rdata,  // head byte
    input  wire logic       stall        // refuse words while high
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [16];
    logic [3:0] wp;
    logic [3:0] rp;
    logic [7:0] last;
    logic       push;
    logic       pull;
    assign fifo_wready = !stall && fifo_count != 5'h10;
    assign push        = fifo_wvalid && fifo_wready;
    assign pull        = fifo_pop && fifo_count != 5'h0;
    // no stale head when empty: show a changing pattern
    assign fifo_rdata  = (fifo_count != 5'h0) ? mem[rp] : ~last;
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn || fifo_reset)
        begin
            wp <= 4'h0;
            rp <= 4'h0;
            fifo_count <= 5'h0;
            last <= 8'h0;
        end
        else
        begin
            if (push)
            begin
                mem[wp] <= fifo_wdata[7:0];
                wp <= wp + 4'h1;
            end
            if (pull)
                rp <= rp + 4'h1;
            last <= fifo_rdata;
            fifo_count <= fifo_count + {4'h0, push} - {4'h0, pull};
        end
    end
endmodule

// ---- bench/testbench.sv ----
// register level regression of the extended control block
`define CHK(n, e, a) begin num_checks++; if ((e) !== (a)) begin err_count++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, resetn, reg_wr, reg_rd, direction, fault_n, dma_tc, stall;
    logic irq_lvl, epp_opt, data_tristate, data_read_pins, compat_send, ecp_fwd, ecp_rev, epp_active;
    logic [10:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, fifo_rdata, v;
    logic [4:0]  fifo_count;
    logic [8:0]  fifo_wdata;
    logic [2:0]  mode;
    logic reg_rvalid, reg_wready, fifo_pop, fifo_wvalid, fifo_wready, fifo_reset, ctrl_open_drain;
    logic dma_allow, irq_o, irq_oe;
    int   err_count, num_checks;
    ecpx_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_wready(reg_wready), .direction(direction), .peripheral_fault_n(fault_n),
        .irq_line_level(irq_lvl), .irq_num(4'ha), .dma_num(3'h2), .epp_option_config(epp_opt),
        .dma_tc(dma_tc), .fifo_count(fifo_count), .fifo_rdata(fifo_rdata), .fifo_pop(fifo_pop),
        .fifo_wdata(fifo_wdata), .fifo_wvalid(fifo_wvalid), .fifo_wready(fifo_wready), .mode(mode),
        .fifo_reset(fifo_reset), .ctrl_open_drain(ctrl_open_drain), .data_tristate(data_tristate),
        .data_read_pins(data_read_pins), .compat_send(compat_send), .ecp_fwd(ecp_fwd), .ecp_rev(ecp_rev),
        .epp_active(epp_active),
        .dma_allow(dma_allow), .irq_o(irq_o), .irq_oe(irq_oe));
    ecpx_fifo_model fm (.ref_clk(ref_clk), .resetn(resetn), .fifo_reset(fifo_reset),
        .fifo_wdata(fifo_wdata), .fifo_wvalid(fifo_wvalid), .fifo_wready(fifo_wready),
        .fifo_pop(fifo_pop), .fifo_count(fifo_count), .fifo_rdata(fifo_rdata), .stall(stall));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("rvalid", 1'b1, reg_rvalid)
        d = reg_rdata;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // pulse must start within bound cycles and last exactly 8
    task automatic pulse(input int bound);
        int i;
        int len;
        i = 0;
        len = 0;
        while (irq_oe !== 1'b1 && i < bound)
        begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        `CHK("irq start", 1'b1, irq_oe)
        if (irq_oe !== 1'b1)
            results();
        while (irq_oe === 1'b1 && len < 20)
        begin
            `CHK("irq low", 1'b0, irq_o)
            @(posedge ref_clk);
            #1;
            len++;
        end
        `CHK("pulse len", 8, len)
    endtask
    task automatic quiet(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            #1;
            `CHK("no irq", 1'b0, irq_oe)
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {resetn, reg_wr, reg_rd, direction, dma_tc, stall} = 6'h0;
        fault_n = 1'b1;
        irq_lvl = 1'b1;
        epp_opt = 1'b0;
        reg_addr = 11'h0;
        reg_wdata = 8'h0;
        err_count = 0;
        num_checks = 0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(ecpx_pkg::OFF_ECR, v);
        `CHK("ecr reset", 8'h15, v)
        `CHK("fifo reset", 1'b1, fifo_reset)
        `CHK("open drain", 1'b1, ctrl_open_drain)
        `CHK("decode idle", 6'h0, {data_tristate, data_read_pins, compat_send, ecp_fwd, ecp_rev, epp_active})
        wr(ecpx_pkg::OFF_ECR, 8'hf4);
        wr(ecpx_pkg::OFF_FIFO, 8'h00);
        rd(ecpx_pkg::OFF_FIFO, v);
        `CHK("width cfg", 8'h10, v)
        rd(ecpx_pkg::OFF_RES, v);
        `CHK("resource", 8'h5a, v)
        wr(ecpx_pkg::OFF_ECR, 8'hd4);
        rd(ecpx_pkg::OFF_ECR, v);
        `CHK("illegal mode", 8'hf5, v)
        wr(ecpx_pkg::OFF_ECR, 8'h14);
        wr(ecpx_pkg::OFF_ECR, 8'hd4);
        stall <= 1'b1;
        wr(ecpx_pkg::OFF_FIFO, 8'ha1);
        wr(ecpx_pkg::OFF_FIFO, 8'hb2);
        `CHK("buffer full", 1'b0, reg_wready)
        `CHK("head word", 9'h0a1, fifo_wdata)
        rd(ecpx_pkg::OFF_ECR, v);
        `CHK("full bits", 8'hd6, v)
        stall <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(ecpx_pkg::OFF_FIFO, v);
        `CHK("test read", 8'ha1, v)
        wr(ecpx_pkg::OFF_ECR, 8'hd0);
        pulse(5);
        rd(ecpx_pkg::OFF_ECR, v);
        `CHK("mask set", 8'hd4, v)
        @(posedge ref_clk);
        direction <= 1'b1;
        wr(ecpx_pkg::OFF_ECR, 8'hd0);
        quiet(4);
        for (int k = 0; k < 7; k++)
            wr(ecpx_pkg::OFF_FIFO, 8'(k));
        pulse(8);
        @(posedge ref_clk);
        direction <= 1'b0;
        wr(ecpx_pkg::OFF_ECR, 8'hd8);
        `CHK("dma on", 1'b1, dma_allow)
        quiet(3);
        @(posedge ref_clk);
        dma_tc <= 1'b1;
        @(posedge ref_clk);
        dma_tc <= 1'b0;
        #1;
        pulse(5);
        `CHK("dma masked", 1'b0, dma_allow)
        wr(ecpx_pkg::OFF_ECR, 8'h14);
        wr(ecpx_pkg::OFF_ECR, 8'h74);
        `CHK("ecp fwd", 1'b1, ecp_fwd)
        stall <= 1'b1;
        wr(ecpx_pkg::OFF_CMDQ, 8'h3c);
        `CHK("cmd word", 9'h13c, fifo_wdata)
        stall <= 1'b0;
        @(posedge ref_clk);
        fault_n <= 1'b0;
        quiet(5);
        wr(ecpx_pkg::OFF_ECR, 8'h64);
        pulse(6);
        @(posedge ref_clk);
        fault_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        fault_n <= 1'b0;
        pulse(8);
        wr(ecpx_pkg::OFF_ECR, 8'h34);
        `CHK("read pins", 2'h2, {data_read_pins, ctrl_open_drain})
        @(posedge ref_clk);
        direction <= 1'b1;
        @(posedge ref_clk);
        #1;
        `CHK("tristate", 1'b1, data_tristate)
        wr(ecpx_pkg::OFF_ECR, 8'h74);
        `CHK("ecp rev", 2'h1, {ecp_fwd, ecp_rev})
        wr(ecpx_pkg::OFF_ECR, 8'h34);
        @(posedge ref_clk);
        direction <= 1'b0;
        wr(ecpx_pkg::OFF_ECR, 8'h54);
        `CHK("compat", 2'h2, {compat_send, data_tristate})
        wr(ecpx_pkg::OFF_ECR, 8'h34);
        wr(ecpx_pkg::OFF_ECR, 8'h94);
        `CHK("epp off", 1'b0, epp_active)
        @(posedge ref_clk);
        epp_opt <= 1'b1;
        irq_lvl <= 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK("epp on", 1'b1, epp_active)
        wr(ecpx_pkg::OFF_ECR, 8'h34);
        wr(ecpx_pkg::OFF_ECR, 8'hb8);
        `CHK("reserved dma", 1'b0, dma_allow)
        wr(ecpx_pkg::OFF_ECR, 8'h34);
        wr(ecpx_pkg::OFF_ECR, 8'hf4);
        rd(ecpx_pkg::OFF_RES, v);
        `CHK("irq level", 8'h1a, v)
        results();
    end
endmodule

// ---- verilog/ecpx_ctrl.sv ----
// extended control, configuration and service interrupt logic of an ecp parallel port
module ecpx_ctrl #(
    parameter int FIFO_DEPTH = 16,              // fifo storage depth in bytes
    parameter int TX_THR     = 8,               // free bytes that request service
    parameter int RX_THR     = 8,               // valid bytes that request service
    parameter int CW         = $clog2(FIFO_DEPTH + 1)
) (
    input  wire logic          ref_clk,         // system clock
    input  wire logic          resetn,          // async reset, low
    input  wire logic [10:0]   reg_addr,        // offset from port base
    input  wire logic          reg_wr,          // write strobe, one cycle
    input  wire logic          reg_rd,          // read strobe, one cycle
    input  wire logic [7:0]    reg_wdata,       // write byte
    output logic      [7:0]    reg_rdata,       // read byte
    output logic               reg_rvalid,      // read byte valid pulse
    output logic               reg_wready,      // fifo writes can be taken
    input  wire logic          direction,       // port direction, 1 reverse
    input  wire logic          peripheral_fault_n, // fault pin, async
    input  wire logic          irq_line_level,  // isa irq line level, async
    input  wire logic [3:0]    irq_num,         // assigned irq number
    input  wire logic [2:0]    dma_num,         // assigned dma channel
    input  wire logic          epp_option_config, // epp option enabled
    input  wire logic          dma_tc,          // dma terminal count pulse
    input  wire logic [CW-1:0] fifo_count,      // bytes held in fifo storage
    input  wire logic [7:0]    fifo_rdata,      // head byte of fifo
    output logic               fifo_pop,        // take head byte, pulse
    output logic [8:0]         fifo_wdata,      // {command tag, byte}
    output logic               fifo_wvalid,     // write word valid
    input  wire logic          fifo_wready,     // fifo storage accepts
    output logic [2:0]         mode,            // current mode selector
    output logic               fifo_reset,      // hold fifo in reset
    output logic               ctrl_open_drain, // control lines open collector
    output logic               data_tristate,   // release data lines
    output logic               data_read_pins,  // data read returns pins
    output logic               compat_send,     // compatibility fifo sender on
    output logic               ecp_fwd,         // ecp forward handshake on
    output logic               ecp_rev,         // ecp reverse handshake on
    output logic               epp_active,      // epp operation selected
    output logic               dma_allow,       // dma requests permitted
    output logic               irq_o,           // interrupt pin level
    output logic               irq_oe           // interrupt pin drive enable
);

    ////////////////////////////////////////////////////////////////////////////
    // parameter checks

    if (FIFO_DEPTH < 2 || TX_THR < 1 || TX_THR > FIFO_DEPTH || RX_THR < 1 || RX_THR > FIFO_DEPTH)
    begin : g_bad_param
        $error("ecpx_ctrl: fifo depth or thresholds out of range");
    end

    if (CW != $clog2(FIFO_DEPTH + 1))
    begin : g_bad_width
        // a narrower count port would wrap the free byte sum
        $error("ecpx_ctrl: fifo count width does not suit the depth");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic                       fault_s1;
        logic                       fault_s2;
        logic                       fault_prev;
        logic                       irql_s1;
        logic                       irql_s2;
        logic [2:0]                 mode;
        logic                       fault_dis;
        logic                       dma_en;
        logic                       svc_mask;
        logic [7:0]                 rdata;
        logic                       rvalid;
        logic                       pop;
        logic [ecpx_pkg::IRQ_CW-1:0] irq_cnt;
        logic                       irq_o;
        logic                       irq_oe;
        logic                       dma_allow;
        logic                       fifo_reset;
        logic                       ctrl_od;
        logic                       data_tri;
        logic                       data_pins;
        logic                       compat_send;
        logic                       ecp_fwd;
        logic                       ecp_rev;
        logic                       epp_on;
        logic [1:0][8:0]            b_data;
        logic [1:0]                 b_cnt;
        logic                       wvalid;
        logic                       wready;
    } ecpx_state_t;

    localparam ecpx_state_t RST = '{
        fault_s1: 1'b1, fault_s2: 1'b1, fault_prev: 1'b1,
        irql_s1: 1'b0, irql_s2: 1'b0,
        mode: ecpx_pkg::ECR_MODE_RST, fault_dis: ecpx_pkg::ECR_FDIS_RST,
        dma_en: ecpx_pkg::ECR_DMA_ENABLE_BIT_RST, svc_mask: ecpx_pkg::ECR_SVC_RST,
        rdata: 8'h00, rvalid: 1'b0, pop: 1'b0, irq_cnt: '0, irq_o: 1'b1, irq_oe: 1'b0,
        dma_allow: 1'b0, fifo_reset: 1'b1, ctrl_od: 1'b1, data_tri: 1'b0, data_pins: 1'b0,
        compat_send: 1'b0, ecp_fwd: 1'b0, ecp_rev: 1'b0, epp_on: 1'b0,
        b_data: '0, b_cnt: 2'h0, wvalid: 1'b0, wready: 1'b1
    };

    ecpx_state_t q;
    ecpx_state_t d;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic          cfg_mode;
    logic          fifo_mode;
    logic          fault_fall;
    logic          fault_fire;
    logic          svc_cond;
    logic          svc_fire;
    logic          ecr_wr;
    logic          fifo_full;
    logic          fifo_empty;
    logic [CW-1:0] free_cnt;
    logic          push;
    logic          drain;
    logic [8:0]    push_word;
    logic [2:0]    new_mode;
    logic [7:0]    ecr_val;
    logic [7:0]    res_val;

    always_comb
    begin
        d = q;
        // the first stage only feeds the second
        d.fault_s1   = peripheral_fault_n;
        d.fault_s2   = q.fault_s1;
        d.fault_prev = q.fault_s2;
        d.irql_s1    = irq_line_level;
        d.irql_s2    = q.irql_s1;

        cfg_mode   = (q.mode == ecpx_pkg::MODE_CFG);
        fifo_mode  = (q.mode == ecpx_pkg::MODE_COMPAT) || (q.mode == ecpx_pkg::MODE_ECP)
                     || (q.mode == ecpx_pkg::MODE_TEST);
        ecr_wr     = reg_wr && (reg_addr == ecpx_pkg::OFF_ECR);
        free_cnt   = CW'(FIFO_DEPTH) - fifo_count;
        fifo_full  = (fifo_count == CW'(FIFO_DEPTH)) || !q.wready;
        fifo_empty = (fifo_count == '0) && !q.wvalid;

        // fault interrupt, edge or re-enable while already faulted
        fault_fall = q.fault_prev && !q.fault_s2;
        fault_fire = (q.mode == ecpx_pkg::MODE_ECP)
                     && ((!q.fault_dis && fault_fall)
                         || (q.fault_dis && ecr_wr && !reg_wdata[ecpx_pkg::ECR_FDIS]
                             && !q.fault_s2));

        // threshold service condition is a level, so clearing the mask fires it at once; with dma enabled it waits for the dma_tc pulse
        if (q.dma_en)
            svc_cond = dma_tc;
        else if (!direction)
            svc_cond = (free_cnt >= CW'(TX_THR));
        else
            svc_cond = (fifo_count >= CW'(RX_THR));
        svc_fire = fifo_mode && !q.svc_mask && svc_cond;

        // extended control write; illegal mode hops are ignored
        new_mode = reg_wdata[ecpx_pkg::ECR_MODE_LSB +: 3];
        if (ecr_wr)
        begin
            if ((q.mode == ecpx_pkg::MODE_SPP) || (q.mode == ecpx_pkg::MODE_BIDIR)
                || (new_mode == ecpx_pkg::MODE_SPP) || (new_mode == ecpx_pkg::MODE_BIDIR))
                d.mode = new_mode;
            d.fault_dis = reg_wdata[ecpx_pkg::ECR_FDIS];
            d.dma_en    = reg_wdata[ecpx_pkg::ECR_DMA_ENABLE_BIT];
            d.svc_mask  = reg_wdata[ecpx_pkg::ECR_SVC];
        end
        // hardware set wins over a software clear in the same cycle
        if (svc_fire)
            d.svc_mask = 1'b1;

        // interrupt pulse: drive low for a fixed time, then release
        if (svc_fire || fault_fire)
            d.irq_cnt = ecpx_pkg::IRQ_CW'(ecpx_pkg::IRQ_PULSE_CYC);
        else if (q.irq_cnt != '0)
            d.irq_cnt = q.irq_cnt - ecpx_pkg::IRQ_CW'(1);
        d.irq_oe = (d.irq_cnt != '0);
        d.irq_o  = !d.irq_oe;

        // register reads, answered one cycle later
        ecr_val = {q.mode, q.fault_dis, q.dma_en, q.svc_mask, fifo_full, fifo_empty};
        res_val = {1'b0, q.irql_s2, ecpx_pkg::ecpx_irq_code(irq_num),
                   ecpx_pkg::ecpx_dma_code(dma_num)};
        d.rvalid = reg_rd;
        d.pop    = 1'b0;
        d.rdata  = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                ecpx_pkg::OFF_FIFO:
                begin
                    if (cfg_mode)
                        d.rdata = ecpx_pkg::PORT_WIDTH_VAL;
                    else if (fifo_mode)
                    begin
                        d.rdata = fifo_rdata;
                        d.pop   = 1'b1;
                    end
                end
                ecpx_pkg::OFF_RES:
                    if (cfg_mode)
                        d.rdata = res_val;
                ecpx_pkg::OFF_ECR:
                    d.rdata = ecr_val;
                default:
                    d.rdata = 8'h00;
            endcase
        end

        // host fifo writes go through a two-entry buffer
        push_word = '0;
        push      = 1'b0;
        if (reg_wr && q.wready)
        begin
            if ((reg_addr == ecpx_pkg::OFF_FIFO) && fifo_mode)
            begin
                push      = 1'b1;
                push_word = {1'b0, reg_wdata};
            end
            else if ((reg_addr == ecpx_pkg::OFF_CMDQ) && (q.mode == ecpx_pkg::MODE_ECP) && !direction)
            begin
                push      = 1'b1;
                push_word = {1'b1, reg_wdata};
            end
        end
        drain = q.wvalid && fifo_wready;
        if (drain)
            d.b_data[0] = q.b_data[1];
        if (push)
            d.b_data[q.b_cnt - {1'b0, drain}] = push_word;
        d.b_cnt  = q.b_cnt + {1'b0, push} - {1'b0, drain};
        if (q.mode == ecpx_pkg::MODE_SPP)
            d.b_cnt = 2'h0;
        d.wvalid = (d.b_cnt != 2'h0);
        d.wready = (d.b_cnt != 2'h2);

        // mode decode for the port drivers and handshake engines
        d.fifo_reset  = (d.mode == ecpx_pkg::MODE_SPP);
        d.ctrl_od     = (d.mode == ecpx_pkg::MODE_SPP);
        d.data_tri    = direction && (d.mode != ecpx_pkg::MODE_SPP)
                        && (d.mode != ecpx_pkg::MODE_COMPAT);
        d.data_pins   = (d.mode == ecpx_pkg::MODE_BIDIR);
        d.compat_send = (d.mode == ecpx_pkg::MODE_COMPAT) && !direction;
        d.ecp_fwd     = (d.mode == ecpx_pkg::MODE_ECP) && !direction;
        d.ecp_rev     = (d.mode == ecpx_pkg::MODE_ECP) && direction;
        d.epp_on      = (d.mode == ecpx_pkg::MODE_EPP) && epp_option_config;
        d.dma_allow   = d.dma_en && !d.svc_mask && (d.mode != ecpx_pkg::MODE_RSVD)
                        && (d.mode != ecpx_pkg::MODE_SPP);
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            q <= RST;
        else
            q <= d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata       = q.rdata;
    assign reg_rvalid      = q.rvalid;
    assign reg_wready      = q.wready;
    assign fifo_pop        = q.pop;
    assign fifo_wdata      = q.b_data[0];
    assign fifo_wvalid     = q.wvalid;
    assign mode            = q.mode;
    assign fifo_reset      = q.fifo_reset;
    assign ctrl_open_drain = q.ctrl_od;
    assign data_tristate   = q.data_tri;
    assign data_read_pins  = q.data_pins;
    assign compat_send     = q.compat_send;
    assign ecp_fwd         = q.ecp_fwd;
    assign ecp_rev         = q.ecp_rev;
    assign epp_active      = q.epp_on;
    assign dma_allow       = q.dma_allow;
    assign irq_o           = q.irq_o;
    assign irq_oe          = q.irq_oe;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    cfg_width_read_a: assert property ((reg_rd && reg_addr == ecpx_pkg::OFF_FIFO && cfg_mode)
        |=> (reg_rvalid && reg_rdata == ecpx_pkg::PORT_WIDTH_VAL))
        else $error("port width read wrong");
    compress_bit_a: assert property ((reg_rd && reg_addr == ecpx_pkg::OFF_RES && cfg_mode)
        |=> !reg_rdata[ecpx_pkg::RES_COMPRESS])
        else $error("compress bit not zero");
    irq_value_a: assert property ((reg_rd && reg_addr == ecpx_pkg::OFF_RES && cfg_mode)
        |=> reg_rdata[ecpx_pkg::RES_IRQVAL] == $past(q.irql_s2))
        else $error("irq value bit wrong");
    mode_write_a: assert property ((ecr_wr && q.mode == ecpx_pkg::MODE_SPP)
        |=> mode == $past(new_mode))
        else $error("mode not written");
    mode_hop_a: assert property ((ecr_wr && q.mode == ecpx_pkg::MODE_ECP && new_mode == ecpx_pkg::MODE_TEST)
        |=> mode == ecpx_pkg::MODE_ECP)
        else $error("illegal mode hop taken");
    fault_pulse_a: assert property ((mode == ecpx_pkg::MODE_ECP && !q.fault_dis && fault_fall)
        |=> (irq_oe && !irq_o))
        else $error("fault edge gave no interrupt");
    svc_mask_set_a: assert property (svc_fire |=> (q.svc_mask && irq_oe))
        else $error("service event did not set mask");
    mask_quiet_a: assert property ((ecr_wr && reg_wdata[ecpx_pkg::ECR_SVC] && q.svc_mask
        && mode != ecpx_pkg::MODE_ECP && !irq_oe) |=> !irq_oe)
        else $error("mask write raised interrupt");
    dma_gate_a: assert property (dma_allow |-> (q.dma_en && !q.svc_mask))
        else $error("dma allowed while gated");
    pulse_width_a: assert property ($rose(irq_oe) |-> (irq_oe && !irq_o) [*8])
        else $error("interrupt pulse too short");
    empty_bit_a: assert property ((reg_rd && reg_addr == ecpx_pkg::OFF_ECR)
        |=> reg_rdata[ecpx_pkg::ECR_EMPTY] == $past(fifo_empty))
        else $error("empty bit wrong");
    spp_reset_a: assert property ((mode == ecpx_pkg::MODE_SPP) |-> (fifo_reset && ctrl_open_drain))
        else $error("spp mode not holding fifo reset");

    // service conditions restated from the threshold and terminal count terms, not from svc_fire, then full bit and fault mute checks
    free_bytes_irq_a: assert property ((fifo_mode && !q.svc_mask && !q.dma_en && !direction
        && fifo_count <= CW'(FIFO_DEPTH - TX_THR)) |=> (irq_oe && !irq_o))
        else $error("free byte threshold gave no interrupt");
    fill_level_irq_a: assert property ((fifo_mode && !q.svc_mask && !q.dma_en && direction
        && fifo_count >= CW'(RX_THR)) |=> (irq_oe && !irq_o))
        else $error("fill threshold gave no interrupt");
    dma_tc_irq_a: assert property ((fifo_mode && !q.svc_mask && q.dma_en && dma_tc)
        |=> (irq_oe && q.svc_mask))
        else $error("terminal count gave no interrupt");
    full_bit_a: assert property ((reg_rd && reg_addr == ecpx_pkg::OFF_ECR
        && (fifo_count == CW'(FIFO_DEPTH) || !reg_wready)) |=> reg_rdata[ecpx_pkg::ECR_FULL])
        else $error("full bit not set");
    fault_mute_a: assert property ((mode == ecpx_pkg::MODE_ECP && q.fault_dis && fault_fall
        && !ecr_wr && !svc_fire && !irq_oe) |=> !irq_oe)
        else $error("disabled fault edge interrupted");

    tc_irq_c: cover property (q.dma_en && dma_tc && svc_fire);
    fault_irq_c: cover property (fault_fire ##1 irq_oe);
    buf_full_c: cover property (!reg_wready ##1 fifo_wready);
    mask_clear_c: cover property (q.svc_mask ##1 svc_fire);
    cfg_read_c: cover property (reg_rd && cfg_mode && reg_addr == ecpx_pkg::OFF_RES);

endmodule

// ---- verilog/ecpx_pkg.sv ----
// constants and lookups for the ecp extended control register block
package ecpx_pkg;

    // register offsets from the port base
    localparam logic [10:0] OFF_CMDQ = 11'h000;
    localparam logic [10:0] OFF_FIFO = 11'h400;
    localparam logic [10:0] OFF_RES  = 11'h401;
    localparam logic [10:0] OFF_ECR  = 11'h402;

    localparam logic [7:0] PORT_WIDTH_VAL = 8'h10;

    // mode selector codes
    localparam logic [2:0] MODE_SPP    = 3'h0;
    localparam logic [2:0] MODE_BIDIR  = 3'h1;
    localparam logic [2:0] MODE_COMPAT = 3'h2;
    localparam logic [2:0] MODE_ECP    = 3'h3;
    localparam logic [2:0] MODE_EPP    = 3'h4;
    localparam logic [2:0] MODE_RSVD   = 3'h5;
    localparam logic [2:0] MODE_TEST   = 3'h6;
    localparam logic [2:0] MODE_CFG    = 3'h7;

    // extended control field positions
    localparam int ECR_MODE_LSB = 5;
    localparam int ECR_FDIS     = 4;
    localparam int ECR_DMA_ENABLE_BIT    = 3;
    localparam int ECR_SVC      = 2;
    localparam int ECR_FULL     = 1;
    localparam int ECR_EMPTY    = 0;

    // resource config field positions
    localparam int RES_COMPRESS = 7;
    localparam int RES_IRQVAL   = 6;

    // extended control reset values
    localparam logic [2:0] ECR_MODE_RST  = 3'h0;
    localparam logic       ECR_FDIS_RST  = 1'b1;
    localparam logic       ECR_DMA_ENABLE_BIT_RST = 1'b0;
    localparam logic       ECR_SVC_RST   = 1'b1;

    // interrupt pulse width, least time
    localparam int CLK_PERIOD_NS = 10;
    localparam int IRQ_PULSE_NS  = 80;
    localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IRQ_CW        = $clog2(IRQ_PULSE_CYC + 1);

    function automatic logic [2:0] ecpx_irq_code(input logic [3:0] n);
        case (n)
            4'hf:    return 3'h6;
            4'he:    return 3'h5;
            4'hb:    return 3'h4;
            4'ha:    return 3'h3;
            4'h9:    return 3'h2;
            4'h7:    return 3'h1;
            4'h5:    return 3'h7;
            default: return 3'h0;
        endcase
    endfunction

    function automatic logic [2:0] ecpx_dma_code(input logic [2:0] n);
        case (n)
            3'h3:    return 3'h3;
            3'h2:    return 3'h2;
            3'h1:    return 3'h1;
            default: return 3'h0;
        endcase
    endfunction

endpackage
